// file: src/cirp_core.sv
// The implementer's own choice: the Avalon-MM register port.
module cirp_core (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Avalon-MM slave
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic [1:0] AVS_RESPONSE,
  output logic AVS_WAITREQUEST,
  // Core sequencer
  input wire cirp_pkg::cirp_core_ctl_t CORE_CTL,
  output logic [12:0] PC_OUT,
  output logic IRQ_REQ,
  // Peripheral events and reset cause
  input wire cirp_pkg::cirp_evt_t EVT,
  input wire logic RST_WAS_POR,
  input wire logic RST_WAS_BOR,
  // Port pins and port-change control
  input wire logic [5:0] GPIO_PINS,
  input wire logic [5:0] PORT_CHANGE_EN,
  input wire logic PORT_READ,
  // Oscillator trim
  output logic [5:0] TRIM_VALUE
);

  // Bus handshake
  logic wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] resp_ff, nxt_resp;
  logic [7:0] idx;
  logic hit, acc, wr_go;
  logic [7:0] wbyte, rbyte;

  // Register state
  logic [7:0] intctl_ff, nxt_intctl;
  logic [7:0] pirf_ff, nxt_pirf;
  logic [7:0] pien_ff, nxt_pien;
  logic [1:0] cause_ff, nxt_cause;
  logic [5:0] trim_ff, nxt_trim;
  logic [4:0] latch_ff, nxt_latch;
  logic released_ff, nxt_released;
  logic cmp_prev_ff, nxt_cmp_prev;
  logic irq_ff, nxt_irq;

  // Program counter and stack
  logic [12:0] pc_ff, nxt_pc;
  logic [2:0] sp_ff, nxt_sp;
  logic [12:0] stack_ff [cirp_pkg::STACK_DEPTH];
  logic [12:0] nxt_stack [cirp_pkg::STACK_DEPTH];
  logic push, pop;

  // Pin synchroniser and port-change compare
  logic [5:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff;
  logic [5:0] nxt_pin;
  logic [5:0] port_snap_ff, nxt_port_snap;
  logic mismatch;

  assign idx = AVS_ADDRESS[9:2];
  assign acc = (AVS_READ | AVS_WRITE) & wait_ff;
  // Write lands on the edge where waitrequest is seen low
  assign wr_go = AVS_WRITE & ~wait_ff & AVS_BYTEENABLE[0] & hit;
  assign wbyte = AVS_WRITEDATA[7:0];

  always_comb begin
    case (idx)
      cirp_pkg::IDX_PCL, cirp_pkg::IDX_PCLATCH, cirp_pkg::IDX_INTCTL,
      cirp_pkg::IDX_PIRF, cirp_pkg::IDX_PIEN, cirp_pkg::IDX_RSTCAUSE,
      cirp_pkg::IDX_TRIM: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    case (idx)
      cirp_pkg::IDX_PCL: rbyte = pc_ff[7:0];
      cirp_pkg::IDX_PCLATCH: rbyte = {3'h0, latch_ff};
      cirp_pkg::IDX_INTCTL: rbyte = intctl_ff;
      cirp_pkg::IDX_PIRF: rbyte = pirf_ff & cirp_pkg::PERIPH_MASK;
      cirp_pkg::IDX_PIEN: rbyte = pien_ff & cirp_pkg::PERIPH_MASK;
      cirp_pkg::IDX_RSTCAUSE: rbyte = {6'h00, cause_ff};
      cirp_pkg::IDX_TRIM: rbyte = {trim_ff, 2'h0};
      default: rbyte = 8'h00;
    endcase
  end

  // One wait cycle on every access keeps read data registered
  always_comb begin
    nxt_wait = ~acc;
    nxt_rdata = rdata_ff;
    nxt_resp = resp_ff;
    if (acc) begin
      nxt_rdata = AVS_READ ? {24'h000000, rbyte} : 32'h00000000;
      nxt_resp = hit ? cirp_pkg::RESP_OK : cirp_pkg::RESP_DECERR;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
      resp_ff <= cirp_pkg::RESP_OK;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
    end
  end

  // Port pins: three stages, value accepted once stages two and three agree
  always_comb begin
    nxt_pin = pin_ff;
    for (int i = 0; i < 6; i++) begin
      if (pin_s2_ff[i] == pin_s3_ff[i]) begin
        nxt_pin[i] = pin_s3_ff[i];
      end
    end
    nxt_port_snap = PORT_READ ? pin_ff : port_snap_ff;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_s1_ff <= 6'h00;
      pin_s2_ff <= 6'h00;
      pin_s3_ff <= 6'h00;
      pin_ff <= 6'h00;
      port_snap_ff <= 6'h00;
    end else begin
      pin_s1_ff <= GPIO_PINS;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff <= nxt_pin;
      port_snap_ff <= nxt_port_snap;
    end
  end

  assign mismatch = |((pin_ff ^ port_snap_ff) & PORT_CHANGE_EN);

  // Flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    logic wr_ic, wr_pf;
    wr_ic = wr_go && idx == cirp_pkg::IDX_INTCTL;
    wr_pf = wr_go && idx == cirp_pkg::IDX_PIRF;
    nxt_intctl = wr_ic ? wbyte : intctl_ff;
    nxt_pirf = wr_pf ? (wbyte & cirp_pkg::PERIPH_MASK) : pirf_ff;
    nxt_intctl[cirp_pkg::B_T0FL] = nxt_intctl[cirp_pkg::B_T0FL] | EVT.tmr0_ovf;
    nxt_intctl[cirp_pkg::B_EXTFL] = nxt_intctl[cirp_pkg::B_EXTFL] | EVT.ext_int;
    // A standing mismatch keeps the flag up until the port is read
    nxt_intctl[cirp_pkg::B_PCFL] = nxt_intctl[cirp_pkg::B_PCFL] | mismatch;
    if (CORE_CTL.irq_branch) begin
      nxt_intctl[cirp_pkg::B_GIE] = 1'b0;
    end else if (CORE_CTL.return_from_interrupt_op) begin
      nxt_intctl[cirp_pkg::B_GIE] = 1'b1;
    end
    nxt_pirf[cirp_pkg::B_EE] = nxt_pirf[cirp_pkg::B_EE] | EVT.ee_done;
    nxt_pirf[cirp_pkg::B_AD] = nxt_pirf[cirp_pkg::B_AD] | EVT.adc_done;
    nxt_pirf[cirp_pkg::B_CM] = nxt_pirf[cirp_pkg::B_CM] | (EVT.cmp_out ^ cmp_prev_ff);
    nxt_pirf[cirp_pkg::B_T1] = nxt_pirf[cirp_pkg::B_T1] | EVT.tmr1_ovf;
    nxt_cmp_prev = EVT.cmp_out;
  end

  // Enables, trim, latch and reset cause
  always_comb begin
    nxt_pien = pien_ff;
    nxt_trim = trim_ff;
    nxt_latch = latch_ff;
    nxt_cause = cause_ff;
    nxt_released = 1'b1;
    if (wr_go && idx == cirp_pkg::IDX_PIEN) begin
      nxt_pien = wbyte & cirp_pkg::PERIPH_MASK;
    end
    if (wr_go && idx == cirp_pkg::IDX_TRIM) begin
      nxt_trim = wbyte[7:2];
    end
    if (wr_go && idx == cirp_pkg::IDX_PCLATCH) begin
      nxt_latch = wbyte[4:0];
    end
    if (wr_go && idx == cirp_pkg::IDX_RSTCAUSE) begin
      nxt_cause = wbyte[1:0];
    end
    // Cause levels are caught on the first edge after reset release
    if (!released_ff) begin
      nxt_cause[cirp_pkg::B_POR] = ~RST_WAS_POR;
      nxt_cause[cirp_pkg::B_BOD] = ~RST_WAS_BOR;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      intctl_ff <= cirp_pkg::RST_INTCTL;
      pirf_ff <= cirp_pkg::RST_PERIPH;
      pien_ff <= cirp_pkg::RST_PERIPH;
      cause_ff <= cirp_pkg::RST_CAUSE;
      trim_ff <= cirp_pkg::RST_TRIM;
      latch_ff <= cirp_pkg::RST_PCLATCH;
      released_ff <= 1'b0;
      cmp_prev_ff <= 1'b0;
    end else begin
      intctl_ff <= nxt_intctl;
      pirf_ff <= nxt_pirf;
      pien_ff <= nxt_pien;
      cause_ff <= nxt_cause;
      trim_ff <= nxt_trim;
      latch_ff <= nxt_latch;
      released_ff <= nxt_released;
      cmp_prev_ff <= nxt_cmp_prev;
    end
  end

  // Interrupt request
  always_comb begin
    logic core_src, periph_src;
    core_src = (intctl_ff[cirp_pkg::B_T0EN] & intctl_ff[cirp_pkg::B_T0FL])
             | (intctl_ff[cirp_pkg::B_EXTEN] & intctl_ff[cirp_pkg::B_EXTFL])
             | (intctl_ff[cirp_pkg::B_PCEN] & intctl_ff[cirp_pkg::B_PCFL]);
    periph_src = intctl_ff[cirp_pkg::B_PGATE] & (|(pien_ff & pirf_ff));
    nxt_irq = intctl_ff[cirp_pkg::B_GIE] & (core_src | periph_src);
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // Program counter and return stack; the latch is never touched here
  assign push = CORE_CTL.irq_branch | CORE_CTL.call;
  // A return that loses to a jump must not move the pointer either
  assign pop = ~push & ~CORE_CTL.jump & (CORE_CTL.ret | CORE_CTL.return_from_interrupt_op);

  always_comb begin
    logic [2:0] top;
    top = sp_ff - 3'h1;
    nxt_pc = pc_ff;
    nxt_sp = sp_ff;
    for (int i = 0; i < cirp_pkg::STACK_DEPTH; i++) begin
      nxt_stack[i] = stack_ff[i];
    end
    if (push) begin
      // Pointer wraps silently, overwriting the oldest entry
      nxt_stack[sp_ff] = pc_ff;
      nxt_sp = sp_ff + 3'h1;
    end else if (pop) begin
      nxt_pc = stack_ff[top];
      nxt_sp = top;
    end
    if (CORE_CTL.irq_branch) begin
      nxt_pc = cirp_pkg::IRQ_VECTOR;
    end else if (CORE_CTL.call || CORE_CTL.jump) begin
      nxt_pc = {latch_ff[4:3], CORE_CTL.target};
    end else if (pop) begin
      nxt_pc = stack_ff[top];
    end else if (wr_go && idx == cirp_pkg::IDX_PCL) begin
      nxt_pc = {latch_ff, wbyte};
    end else if (CORE_CTL.inc) begin
      nxt_pc = pc_ff + 13'h0001;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pc_ff <= cirp_pkg::RST_PC;
      sp_ff <= 3'h0;
    end else begin
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
    end
  end

  // Stack entries hold no reset; contents are undefined until pushed
  genvar g;
  generate
    for (g = 0; g < cirp_pkg::STACK_DEPTH; g++) begin : g_stack
      always_ff @(posedge CLK) begin
        stack_ff[g] <= nxt_stack[g];
      end
    end
  endgenerate

  assign AVS_WAITREQUEST = wait_ff;
  assign AVS_READDATA = rdata_ff;
  assign AVS_RESPONSE = resp_ff;
  assign PC_OUT = pc_ff;
  assign IRQ_REQ = irq_ff;
  assign TRIM_VALUE = trim_ff;

endmodule

// file: src/cirp_pkg.sv
package cirp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PCL = 8'h02;
  localparam logic [7:0] IDX_INTCTL = 8'h0b;
  localparam logic [7:0] IDX_PIRF = 8'h0c;
  localparam logic [7:0] IDX_PCLATCH = 8'h0a;
  localparam logic [7:0] IDX_PIEN = 8'h8c;
  localparam logic [7:0] IDX_RSTCAUSE = 8'h8e;
  localparam logic [7:0] IDX_TRIM = 8'h90;
  // Interrupt control bits
  localparam int B_GIE = 7;
  localparam int B_PGATE = 6;
  localparam int B_T0EN = 5;
  localparam int B_EXTEN = 4;
  localparam int B_PCEN = 3;
  localparam int B_T0FL = 2;
  localparam int B_EXTFL = 1;
  localparam int B_PCFL = 0;
  // Peripheral enable and flag bits
  localparam int B_EE = 7;
  localparam int B_AD = 6;
  localparam int B_CM = 3;
  localparam int B_T1 = 0;
  localparam logic [7:0] PERIPH_MASK = 8'hc9;
  // Reset cause bits
  localparam int B_POR = 1;
  localparam int B_BOD = 0;
  // Reset values, interrupt vector, stack depth and counter width
  localparam logic [7:0] RST_INTCTL = 8'h00;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [1:0] RST_CAUSE = 2'h3;
  localparam logic [5:0] RST_TRIM = 6'h20;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [4:0] RST_PCLATCH = 5'h00;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam int STACK_DEPTH = 8;
  localparam int PC_W = 13;
  // Avalon response codes
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic call;
    logic jump;
    logic ret;
    logic return_from_interrupt_op;
    logic irq_branch;
    logic inc;
    logic [10:0] target;
  } cirp_core_ctl_t;

  typedef struct packed {
    logic ee_done;
    logic adc_done;
    logic cmp_out;
    logic tmr1_ovf;
    logic tmr0_ovf;
    logic ext_int;
  } cirp_evt_t;
endpackage

// file: testbench/cirp_core_props.sv
module cirp_core_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Register bus
  input wire logic [9:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Core side
  input wire cirp_pkg::cirp_core_ctl_t CORE_CTL,
  input wire logic [12:0] PC_OUT,
  input wire logic IRQ_REQ,
  input wire logic [5:0] TRIM_VALUE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  logic [7:0] idx;
  assign idx = AVS_ADDRESS[9:2];

  property p_rst;
    disable iff (1'b0) SYS_RST |-> PC_OUT == 13'h0000 && TRIM_VALUE == 6'h20;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_call;
    (CORE_CTL.call || CORE_CTL.jump) && !CORE_CTL.irq_branch
      |=> PC_OUT[10:0] == $past(CORE_CTL.target);
  endproperty
  a_call: assert property (p_call) else $error("call target lost");
  property p_vec;
    CORE_CTL.irq_branch |=> PC_OUT == cirp_pkg::IRQ_VECTOR;
  endproperty
  a_vec: assert property (p_vec) else $error("no branch to vector");
  // Pop after one idle cycle following a push must hand back the pushed counter
  property p_pop;
    CORE_CTL.call && !CORE_CTL.irq_branch ##1 CORE_CTL == '0 && !AVS_WRITE
      ##1 CORE_CTL.ret && !CORE_CTL.irq_branch && !CORE_CTL.call && !CORE_CTL.jump
      |=> PC_OUT == $past(PC_OUT, 3);
  endproperty
  a_pop: assert property (p_pop) else $error("pop mismatch");
  property p_sticky;
    IRQ_REQ && !AVS_WRITE && !$past(AVS_WRITE) && !CORE_CTL.irq_branch
      && !$past(CORE_CTL.irq_branch) |=> IRQ_REQ;
  endproperty
  a_sticky: assert property (p_sticky) else $error("request dropped");
  property p_unimpl;
    AVS_READ && !AVS_WAITREQUEST && (idx == cirp_pkg::IDX_PIRF || idx == cirp_pkg::IDX_PIEN)
      |-> (AVS_READDATA[7:0] & ~cirp_pkg::PERIPH_MASK) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bits set");
  property p_trim;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && idx == cirp_pkg::IDX_TRIM
      |=> TRIM_VALUE == $past(AVS_WRITEDATA[7:2]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not loaded");
  property p_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
endmodule

bind cirp_core cirp_core_props u_props (.CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
  .CORE_CTL, .PC_OUT, .IRQ_REQ, .TRIM_VALUE);

// file: testbench/cirp_far_model.sv
module cirp_far_model (
  // Clock
  input wire logic clk,
  // Sequencer controls and peripheral events
  output cirp_pkg::cirp_core_ctl_t ctl,
  output cirp_pkg::cirp_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ctl = '0;
  initial evt = '0;
  // Idle cycle after each pulse keeps two pulses from landing in one step
  task automatic op(input logic [16:0] c);
    ctl <= cirp_pkg::cirp_core_ctl_t'(c);
    @(posedge clk);
    ctl <= '0;
    @(posedge clk);
  endtask
  // Comparator output is a level, so it keeps its last value
  task automatic fire(input logic [5:0] e);
    evt <= cirp_pkg::cirp_evt_t'(e);
    @(posedge clk);
    evt <= cirp_pkg::cirp_evt_t'(e & 6'h08);
    @(posedge clk);
  endtask
endmodule

// file: testbench/core_interrupt_reset_pc_stack_test.sv
module core_interrupt_reset_pc_stack_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'b0;
  logic SYS_RST;
  logic [9:0] AVS_ADDRESS;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0] AVS_BYTEENABLE = 4'h1;
  logic [31:0] AVS_READDATA, q;
  logic [1:0] AVS_RESPONSE;
  logic AVS_WAITREQUEST, IRQ_REQ;
  cirp_pkg::cirp_core_ctl_t CORE_CTL;
  cirp_pkg::cirp_evt_t EVT;
  logic [12:0] PC_OUT;
  logic RST_WAS_POR = 1'b1;
  logic RST_WAS_BOR = 1'b0;
  logic [5:0] GPIO_PINS = '0;
  logic [5:0] PORT_CHANGE_EN = '0;
  logic PORT_READ = 1'b0;
  logic [5:0] TRIM_VALUE;
  int error_cnt = 0;
  int n_tests = 0;
  int cycles = 0;

  cirp_core DUT (.CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_RESPONSE, .AVS_WAITREQUEST, .CORE_CTL, .PC_OUT,
    .IRQ_REQ, .EVT, .RST_WAS_POR, .RST_WAS_BOR, .GPIO_PINS, .PORT_CHANGE_EN, .PORT_READ,
    .TRIM_VALUE);
  cirp_far_model FAR (.clk(CLK), .ctl(CORE_CTL), .evt(EVT));

  always #25 CLK = ~CLK;

  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_ADDRESS <= {i, 2'b00};
    AVS_WRITEDATA <= {24'h0, d};
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    bus(1'b0, i, 8'h00);
    chk(q, e);
  endtask

  task automatic t_regs();
    rd(cirp_pkg::IDX_TRIM, 32'h80);
    rd(cirp_pkg::IDX_RSTCAUSE, 32'h1);
    bus(1'b1, cirp_pkg::IDX_RSTCAUSE, 8'hff);
    rd(cirp_pkg::IDX_RSTCAUSE, 32'h3);
    rd(8'h01, 32'h0);
    chk(AVS_RESPONSE, 32'h3);
    bus(1'b1, cirp_pkg::IDX_PIEN, 8'hff);
    rd(cirp_pkg::IDX_PIEN, 32'hc9);
    bus(1'b1, cirp_pkg::IDX_TRIM, 8'hff);
    chk(TRIM_VALUE, 32'h3f);
    AVS_BYTEENABLE <= 4'h0;
    bus(1'b1, cirp_pkg::IDX_TRIM, 8'h00);
    AVS_BYTEENABLE <= 4'h1;
    rd(cirp_pkg::IDX_TRIM, 32'hfc);
    bus(1'b1, cirp_pkg::IDX_INTCTL, 8'h38);
    rd(cirp_pkg::IDX_INTCTL, 32'h38);
  endtask

  task automatic t_flags();
    logic [5:0] ev [4] = '{6'h20, 6'h10, 6'h04, 6'h08};
    logic [7:0] fl [4] = '{8'h80, 8'h40, 8'h01, 8'h08};
    for (int i = 0; i < 4; i++) begin
      FAR.fire(ev[i]);
      rd(cirp_pkg::IDX_PIRF, {24'h0, fl[i]});
      chk(IRQ_REQ, 32'h0);
      bus(1'b1, cirp_pkg::IDX_PIRF, 8'h00);
    end
  endtask

  task automatic t_port();
    PORT_CHANGE_EN <= 6'h01;
    PORT_READ <= 1'b1;
    @(posedge CLK);
    PORT_READ <= 1'b0;
    GPIO_PINS <= 6'h03;
    repeat (8) @(posedge CLK);
    FAR.fire(6'h0b);
    rd(cirp_pkg::IDX_INTCTL, 32'h3f);
    PORT_READ <= 1'b1;
    @(posedge CLK);
    PORT_READ <= 1'b0;
    bus(1'b1, cirp_pkg::IDX_INTCTL, 8'h00);
    rd(cirp_pkg::IDX_INTCTL, 32'h0);
  endtask

  task automatic t_pc();
    bus(1'b1, cirp_pkg::IDX_PCLATCH, 8'h1f);
    bus(1'b1, cirp_pkg::IDX_PCL, 8'h34);
    chk(PC_OUT, 32'h1f34);
    for (int k = 0; k < 9; k++) FAR.op(17'h10000 | 17'(k));
    chk(PC_OUT, 32'h1808);
    FAR.op(17'h0c7ff);
    chk(PC_OUT, 32'h1fff);
    rd(cirp_pkg::IDX_PCLATCH, 32'h1f);
    rd(cirp_pkg::IDX_PCL, 32'hff);
    // Ninth push overwrote the first, so the ninth pop wraps to the newest
    for (int j = 0; j < 9; j++) begin
      FAR.op(17'h04000);
      chk(PC_OUT, 32'h1807 - (j % 8));
    end
    // Call then return hands back the counter that was pushed
    FAR.op(17'h10055);
    chk(PC_OUT, 32'h1855);
    FAR.op(17'h04000);
    chk(PC_OUT, 32'h1807);
  endtask

  task automatic t_irq();
    bus(1'b1, cirp_pkg::IDX_INTCTL, 8'h80);
    FAR.fire(6'h0c);
    repeat (3) @(posedge CLK);
    chk(IRQ_REQ, 32'h0);
    bus(1'b1, cirp_pkg::IDX_INTCTL, 8'hc0);
    repeat (2) @(posedge CLK);
    chk(IRQ_REQ, 32'h1);
    FAR.op(17'h01000);
    chk(PC_OUT, 32'h4);
    @(posedge CLK);
    chk(IRQ_REQ, 32'h0);
    FAR.op(17'h02000);
    chk(PC_OUT, 32'h1807);
    bus(1'b1, cirp_pkg::IDX_PIRF, 8'h00);
    repeat (2) @(posedge CLK);
    chk(IRQ_REQ, 32'h0);
  endtask

  task automatic t_rerun();
    RST_WAS_POR <= 1'b0;
    RST_WAS_BOR <= 1'b1;
    SYS_RST <= 1'b1;
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    chk(PC_OUT, 32'h0);
    rd(cirp_pkg::IDX_RSTCAUSE, 32'h2);
    rd(cirp_pkg::IDX_TRIM, 32'h80);
  endtask

  initial begin
    // Raised by a scheduled update so the reset edge reaches every process
    SYS_RST <= 1'b1;
    AVS_ADDRESS <= '0;
    AVS_WRITEDATA <= '0;
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_flags();
    t_port();
    t_pc();
    t_irq();
    t_rerun();
    test_done();
  end
endmodule
